// [pkg/sdc_pkg.sv]
// Shared constants for the synchronous DRAM command link: widths, pin
// patterns, mode word fields and the controller's register map.
// Assumes both ends and the link interface import it.
package sdc_pkg;
  // ==========================================================================
  // Widths
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int BANK_W = 2;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int AP_BIT = 10;
  // ==========================================================================
  // Mode word fields and reset value (CAS latency 2, burst of 4, linear).
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_CL_LSB = 4;
  localparam int MR_WB_BIT = 9;
  localparam logic [ROW_W-1:0] MR_RST = 12'h022;
  localparam logic [2:0] CL_THREE = 3'h3;
  localparam logic [COL_W-1:0] LAST_PAGE = 8'hFF;
  // ==========================================================================
  // Pin patterns {chip select, row strobe, column strobe, write enable}, all low active.
  typedef enum logic [3:0] {
    PIN_ACT = 4'h3, PIN_PRE = 4'h2, PIN_WR = 4'h4, PIN_RD = 4'h5,
    PIN_MRS = 4'h0, PIN_REF = 4'h1, PIN_STOP = 4'h6, PIN_NOP = 4'h7
  } sdc_pins_t;
  // Controller opcodes carried in the command register.
  typedef enum logic [2:0] {
    OP_NOP = 3'h0, OP_ACT = 3'h1, OP_PRE = 3'h2, OP_RD = 3'h3,
    OP_WR = 3'h4, OP_MRS = 3'h5, OP_REF = 3'h6, OP_STOP = 3'h7
  } sdc_op_t;
  // ==========================================================================
  // Controller registers and command word fields.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_RDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam int CF_BANK = 3;
  localparam int CF_ADDR = 5;
  localparam int CF_MASK = 17;
  localparam int CF_BEATS = 21;
  localparam int ST_ERR = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_REFDUE = 2;
  localparam int ST_OPEN = 4;
  localparam int ST_RDCNT = 8;
  localparam int CT_CKE = 0;
  localparam int CT_REFEN = 1;
  // ==========================================================================
  // Timing: one row refreshed at least every 15.6 us.
  localparam int CLK_NS = 100;
  localparam int REFI_NS = 15600;
  localparam int REFI_CYC = REFI_NS / CLK_NS;
endpackage : sdc_pkg

// [pkg/sdc_if.sv]
// Link between the DRAM controller end and the DRAM device end.
// Assumes both ends share clk_sys; the data bus level is resolved here per lane.
`timescale 1ns/1ps
interface sdc_if;
  import sdc_pkg::*;
  logic cke;
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [BANK_W-1:0] bankSel;
  logic [ROW_W-1:0] addrIn;
  logic [LANES-1:0] byteMask;
  logic [DATA_W-1:0] dqCtlOut;
  logic [LANES-1:0] dqCtlOe;
  logic [DATA_W-1:0] dqDevOut;
  logic [LANES-1:0] dqDevOe;
  logic [DATA_W-1:0] dqBus;

  // ==========================================================================
  // Bus resolution: the device wins a lane it drives, else the controller's value.
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      dqBus[l*8+:8] = dqDevOe[l] ? dqDevOut[l*8+:8] : dqCtlOut[l*8+:8];
    end
  end

  modport dev (input cke, csN, rasN, casN, weN, bankSel, addrIn, byteMask, dqBus,
               output dqDevOut, dqDevOe);
  modport ctl (output cke, csN, rasN, casN, weN, bankSel, addrIn, byteMask, dqCtlOut,
               dqCtlOe, input dqBus, dqDevOe);
endinterface : sdc_if

// [logic/sdc_ctrl.sv]
// Controller end: turns register writes into one DRAM command each, drives
// write data, captures read data and refreshes rows once all banks are closed.
// Assumes a plain register port synchronous to clk_sys.
`timescale 1ns/1ps
module sdc_ctrl (
  sdc_if.ctl link,
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [sdc_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [sdc_pkg::DATA_W-1:0] regRdata
);
  import sdc_pkg::*;
  typedef enum logic [2:0] {S_IDLE = 3'b001, S_ISSUE = 3'b010, S_DATA = 3'b100} sdc_cst_t;
  sdc_cst_t state_ff;
  logic [3:0] pins_ff;
  logic cke_ff, ckeReq_ff, refEn_ff, err_ff, refDue_ff;
  logic [BANK_W-1:0] bank_ff;
  logic [ROW_W-1:0] addr_ff;
  logic [LANES-1:0] mask_ff, dqOe_ff, open_ff;
  logic [DATA_W-1:0] wdata_ff, rdData_ff, dqOut_ff, rdq_ff;
  logic [7:0] beats_ff, rdCount_ff;
  logic [7:0] refTimer_ff;
  logic cmdWr, legal, refGo;
  sdc_op_t op;
  logic [BANK_W-1:0] cBank;

  // Maps an opcode to its pin pattern.
  function automatic logic [3:0] opPins(input sdc_op_t o);
    case (o)
      OP_ACT: opPins = PIN_ACT;
      OP_PRE: opPins = PIN_PRE;
      OP_RD: opPins = PIN_RD;
      OP_WR: opPins = PIN_WR;
      OP_MRS: opPins = PIN_MRS;
      OP_REF: opPins = PIN_REF;
      OP_STOP: opPins = PIN_STOP;
      default: opPins = PIN_NOP;
    endcase
  endfunction : opPins

  assign link.cke = cke_ff;
  assign {link.csN, link.rasN, link.casN, link.weN} = pins_ff;
  assign link.bankSel = bank_ff;
  assign link.addrIn = addr_ff;
  assign link.byteMask = mask_ff;
  assign link.dqCtlOut = dqOut_ff;
  assign link.dqCtlOe = dqOe_ff;
  assign regRdata = rdq_ff;

  // ==========================================================================
  // Command acceptance. A command that breaks bank order is refused and flagged.
  assign cmdWr = regWr && regAddr == REG_CMD;
  assign op = sdc_op_t'(regWdata[2:0]);
  assign cBank = regWdata[CF_BANK+:BANK_W];
  always_comb begin
    case (op)
      OP_ACT: legal = !open_ff[cBank];
      OP_RD, OP_WR: legal = open_ff[cBank];
      OP_MRS, OP_REF: legal = open_ff == '0;
      default: legal = 1'b1;
    endcase
  end
  // Refresh fires only when idle and no command is offered.
  assign refGo = refDue_ff && state_ff == S_IDLE && !cmdWr && open_ff == '0 && cke_ff;

  // ==========================================================================
  // Pin sequencer: one command cycle, then no-operation while write beats remain.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= S_IDLE;
      pins_ff <= PIN_NOP;
      bank_ff <= '0;
      addr_ff <= '0;
      mask_ff <= '0;
      dqOe_ff <= '0;
      dqOut_ff <= '0;
      beats_ff <= '0;
    end else if (clkEn) begin
      pins_ff <= PIN_NOP;
      case (state_ff)
        S_IDLE: begin
          if (cmdWr && legal && cke_ff) begin
            pins_ff <= opPins(op);
            bank_ff <= cBank;
            addr_ff <= regWdata[CF_ADDR+:ROW_W];
            mask_ff <= regWdata[CF_MASK+:LANES];
            beats_ff <= regWdata[CF_BEATS+:8];
            dqOut_ff <= wdata_ff;
            dqOe_ff <= (op == OP_WR) ? ~regWdata[CF_MASK+:LANES] : '0;
            state_ff <= S_ISSUE;
          end else if (refGo) begin
            pins_ff <= PIN_REF;
            state_ff <= S_ISSUE;
          end
        end
        S_ISSUE, S_DATA: begin
          if (dqOe_ff != '0 && beats_ff != 8'h00) begin
            beats_ff <= beats_ff - 8'h01;
            dqOut_ff <= wdata_ff;
            state_ff <= S_DATA;
          end else begin
            dqOe_ff <= '0;
            mask_ff <= '0;
            state_ff <= S_IDLE;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Bank bookkeeping and sticky error; an error set beats a same-cycle clear.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      open_ff <= '0;
      err_ff <= 1'b0;
    end else if (clkEn) begin
      if (cmdWr && state_ff == S_IDLE && legal && cke_ff) begin
        if (op == OP_ACT) open_ff[cBank] <= 1'b1;
        if (op == OP_PRE && regWdata[CF_ADDR+AP_BIT]) open_ff <= '0;
        else if (op == OP_PRE) open_ff[cBank] <= 1'b0;
        if ((op == OP_RD || op == OP_WR) && regWdata[CF_ADDR+AP_BIT]) open_ff[cBank] <= 1'b0;
      end
      if (cmdWr && (state_ff != S_IDLE || !legal || !cke_ff)) err_ff <= 1'b1;
      else if (regWr && regAddr == REG_STATUS && regWdata[ST_ERR]) err_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Refresh interval timer.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      refTimer_ff <= '0;
      refDue_ff <= 1'b0;
    end else if (clkEn) begin
      if (refEn_ff && refTimer_ff == 8'(REFI_CYC - 1)) begin
        refTimer_ff <= '0;
        refDue_ff <= 1'b1;
      end else begin
        if (refEn_ff) refTimer_ff <= refTimer_ff + 8'h01;
        if (refGo) refDue_ff <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Software registers, clock-enable pin and read capture.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ckeReq_ff <= 1'b1;
      refEn_ff <= 1'b0;
      cke_ff <= 1'b1;
      wdata_ff <= '0;
      rdData_ff <= '0;
      rdCount_ff <= '0;
      rdq_ff <= '0;
    end else if (clkEn) begin
      if (regWr && regAddr == REG_CTRL) begin
        ckeReq_ff <= regWdata[CT_CKE];
        refEn_ff <= regWdata[CT_REFEN];
      end
      if (regWr && regAddr == REG_WDATA) wdata_ff <= regWdata;
      // Clock gate drops only with banks idle.
      cke_ff <= ckeReq_ff || open_ff != '0 || state_ff != S_IDLE;
      if (link.dqDevOe != '0) begin
        rdData_ff <= link.dqBus;
        rdCount_ff <= rdCount_ff + 8'h01;
      end
      rdq_ff <= '0;
      if (regRd) begin
        case (regAddr)
          REG_WDATA: rdq_ff <= wdata_ff;
          REG_RDATA: rdq_ff <= rdData_ff;
          REG_STATUS: rdq_ff <= {16'h0000, rdCount_ff, open_ff, 1'b0, refDue_ff,
                                 state_ff != S_IDLE, err_ff};
          REG_CTRL: rdq_ff <= {30'h0, refEn_ff, ckeReq_ff};
          default: rdq_ff <= '0;
        endcase
      end
    end
  end
endmodule : sdc_ctrl

// [logic/sdc_device.sv]
// Device end: decodes DRAM commands, keeps bank and mode state, runs bursts
// against a reduced storage array and drives read data with byte masking.
// Assumes the controller end meets it through sdc_if on the same clk_sys.
// Notes on behaviour
// - Inputs sampled only on rising clock edge.
// - Low clock gate freezes state next cycle.
// - Gate low with idle banks: low power.
// - Low power ignores inputs until gate returns.
// - Bank select picks the addressed bank.
// - Activate latches twelve-bit row address.
// - Column from low bits; bit ten autoprecharge.
// - Precharge bit ten high closes all banks.
// - Mode set loads address as mode word.
// - Chip select high masks every command.
// - Row strobe decode: activate or precharge.
// - Column strobe decode: read or write.
// - Masked lanes drop writes, float bus.
// - Read mask acts two clocks later.
// - Mask bit n covers data byte n.
// - Burst lengths 1,2,4,8 or page.
// - Linear, interleaved, single-write bursts.
// - Burst stop ends burst early.
// - Autoprecharge closes row after burst.
// - Controller refreshes every 15.6 microseconds; this controller holds a due refresh back while any bank is open.
// - Controller activates before read or write.
// - Controller precharges before new row.
`timescale 1ns/1ps
module sdc_device #(
  parameter int STORE_ROW_W = 2
) (
  sdc_if.dev link,
  input wire logic clk_sys,
  input wire logic rstn,
  output logic [sdc_pkg::LANES-1:0] bankOpen,
  output logic powerDown,
  output logic selfRefresh
);
  import sdc_pkg::*;
  localparam int MEM_AW = BANK_W + STORE_ROW_W + COL_W;
  typedef enum logic [2:0] {PW_AWAKE = 3'b001, PW_DOWN = 3'b010, PW_SELF = 3'b100} sdc_pw_t;

  // Storage covers only the low row bits; higher row bits alias.
  logic [DATA_W-1:0] mem [2**MEM_AW];
  sdc_pw_t pwr_ff;
  logic ckePrev_ff;
  logic [ROW_W-1:0] mode_ff;
  logic [LANES-1:0] open_ff;
  logic [ROW_W-1:0] row_ff [LANES];
  logic burstAct_ff, burstWr_ff, autoPre_ff;
  logic [BANK_W-1:0] burstBank_ff;
  logic [COL_W-1:0] startCol_ff, cnt_ff, last_ff;
  logic [DATA_W-1:0] rdData_ff [3];
  logic [2:0] rdVal_ff;
  logic [LANES-1:0] maskPipe_ff [2];
  logic en, actCmd, preCmd, rdCmd, wrCmd, mrsCmd, refCmd, stopCmd;
  logic access, accWr, lastBeat, apClose, allIdle, outVal;
  logic [BANK_W-1:0] accBank;
  logic [COL_W-1:0] accCol, cmdLast;
  logic [MEM_AW-1:0] idx;

  // ==========================================================================
  // Decode helpers.
  // Chip select gates decode.
  function automatic logic isCmd(input logic [3:0] pins, input sdc_pins_t pat);
    isCmd = pins == pat;
  endfunction : isCmd

  function automatic logic [COL_W-1:0] lastIdx(input logic [ROW_W-1:0] m, input logic wr);
    logic [COL_W-1:0] r;
    case (m[MR_BL_LSB+:3])
      3'h1: r = 8'h01;
      3'h2: r = 8'h03;
      3'h3: r = 8'h07;
      3'h7: r = LAST_PAGE;
      default: r = 8'h00;
    endcase
    lastIdx = (wr && m[MR_WB_BIT]) ? 8'h00 : r;
  endfunction : lastIdx

  function automatic logic [COL_W-1:0] colAt(input logic [COL_W-1:0] s, c, l, input logic il);
    colAt = (il && l != LAST_PAGE) ? (s ^ (c & l)) : ((s & ~l) | ((s + c) & l));
  endfunction : colAt

  // ==========================================================================
  // Command decode. Commands count only when the previous edge saw the gate high.
  // Internal clock from sampled gate.
  assign en = ckePrev_ff && pwr_ff == PW_AWAKE;
  always_comb begin
    logic [3:0] p;
    p = {link.csN, link.rasN, link.casN, link.weN};
    actCmd = en && isCmd(p, PIN_ACT);
    preCmd = en && isCmd(p, PIN_PRE);
    rdCmd = en && isCmd(p, PIN_RD);
    wrCmd = en && isCmd(p, PIN_WR);
    mrsCmd = en && isCmd(p, PIN_MRS);
    refCmd = isCmd(p, PIN_REF);
    stopCmd = en && isCmd(p, PIN_STOP);
  end
  assign allIdle = open_ff == '0;
  assign bankOpen = open_ff;
  assign powerDown = pwr_ff == PW_DOWN;
  assign selfRefresh = pwr_ff == PW_SELF;

  // ==========================================================================
  // Current beat: the command edge moves word 0, later edges the rest.
  // Column and autoprecharge from address.
  assign cmdLast = lastIdx(mode_ff, wrCmd);
  assign access = rdCmd || wrCmd || (en && burstAct_ff && !stopCmd);
  assign accWr = (rdCmd || wrCmd) ? wrCmd : burstWr_ff;
  assign accBank = (rdCmd || wrCmd) ? link.bankSel : burstBank_ff;
  assign accCol = (rdCmd || wrCmd) ? link.addrIn[COL_W-1:0] :
                  colAt(startCol_ff, cnt_ff, last_ff, mode_ff[MR_BT_BIT]);
  assign lastBeat = (rdCmd || wrCmd) ? cmdLast == 8'h00 : (access && cnt_ff == last_ff);
  assign apClose = ((rdCmd || wrCmd) && link.addrIn[AP_BIT] && lastBeat) ||
                   (!(rdCmd || wrCmd) && autoPre_ff && burstAct_ff && en &&
                    (lastBeat || stopCmd));
  assign idx = {accBank, row_ff[accBank][STORE_ROW_W-1:0], accCol};

  // ==========================================================================
  // Clock-gate history and power state; low power ignores every other input.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ckePrev_ff <= 1'b0;
      pwr_ff <= PW_AWAKE;
    end else begin
      ckePrev_ff <= link.cke;
      case (pwr_ff)
        PW_AWAKE: begin
          if (ckePrev_ff && !link.cke && allIdle && !burstAct_ff) begin
            pwr_ff <= (!link.csN && refCmd) ? PW_SELF : PW_DOWN;
          end
        end
        PW_DOWN, PW_SELF: if (link.cke) pwr_ff <= PW_AWAKE;
        default: pwr_ff <= PW_AWAKE;
      endcase
    end
  end

  // ==========================================================================
  // Mode word.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_ff <= MR_RST;
    end else if (mrsCmd && allIdle) begin
      mode_ff <= link.addrIn;
    end
  end

  // ==========================================================================
  // Bank state. Autoprecharge is applied first so a same-edge activate wins.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      open_ff <= '0;
      for (int b = 0; b < LANES; b++) row_ff[b] <= '0;
    end else if (en) begin
      if (apClose) open_ff[accBank] <= 1'b0;
      if (actCmd) begin
        open_ff[link.bankSel] <= 1'b1;
        row_ff[link.bankSel] <= link.addrIn;
      end
      if (preCmd && link.addrIn[AP_BIT]) open_ff <= '0;
      else if (preCmd) open_ff[link.bankSel] <= 1'b0;
    end
  end

  // ==========================================================================
  // Burst counter; a new column command cuts an ongoing burst short.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      burstAct_ff <= 1'b0;
      burstWr_ff <= 1'b0;
      autoPre_ff <= 1'b0;
      burstBank_ff <= '0;
      startCol_ff <= '0;
      cnt_ff <= '0;
      last_ff <= '0;
    end else if (en) begin
      if (rdCmd || wrCmd) begin
        burstAct_ff <= cmdLast != 8'h00;
        burstWr_ff <= wrCmd;
        autoPre_ff <= link.addrIn[AP_BIT];
        burstBank_ff <= link.bankSel;
        startCol_ff <= link.addrIn[COL_W-1:0];
        last_ff <= cmdLast;
        cnt_ff <= 8'h01;
      end else if (burstAct_ff) begin
        if (stopCmd || cnt_ff == last_ff) burstAct_ff <= 1'b0;
        else cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Write path: masked lanes keep their old contents.
  always_ff @(posedge clk_sys) begin
    if (access && accWr) begin
      for (int l = 0; l < LANES; l++) begin
        if (!link.byteMask[l]) mem[idx][l*8+:8] <= link.dqBus[l*8+:8];
      end
    end
  end

  // ==========================================================================
  // Read pipeline. Frozen while the gate is low, which holds the data; low power turns the lane enables off.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdVal_ff <= '0;
      for (int s = 0; s < 3; s++) rdData_ff[s] <= '0;
      maskPipe_ff[0] <= '0;
      maskPipe_ff[1] <= '0;
    end else if (en) begin
      rdData_ff[0] <= mem[idx];
      rdData_ff[1] <= rdData_ff[0];
      rdData_ff[2] <= rdData_ff[1];
      rdVal_ff <= {rdVal_ff[1:0], access && !accWr};
      maskPipe_ff[0] <= link.byteMask;
      maskPipe_ff[1] <= maskPipe_ff[0];
    end
  end

  // Latency three takes the later stage; anything else runs at two.
  assign outVal = (mode_ff[MR_CL_LSB+:3] == CL_THREE) ? rdVal_ff[2] : rdVal_ff[1];
  assign link.dqDevOut = (mode_ff[MR_CL_LSB+:3] == CL_THREE) ? rdData_ff[2] : rdData_ff[1];
  for (genvar g = 0; g < LANES; g++) begin : gLane
    assign link.dqDevOe[g] = outVal && !maskPipe_ff[1][g] && pwr_ff == PW_AWAKE;
  end
endmodule : sdc_device

// [verif/sdc_chk.sv]
// Checker for the DRAM command link between the controller and device ends.
// Assumes it sits beside sdc_if and sees the link pins on clk_sys.
`timescale 1ns/1ps
module sdc_chk (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [sdc_pkg::LANES-1:0] byteMask,
  input wire logic [sdc_pkg::LANES-1:0] dqCtlOe,
  input wire logic [sdc_pkg::LANES-1:0] dqDevOe
);
  import sdc_pkg::*;
  logic [3:0] pins;
  // The four command pins seen as one pattern.
  assign pins = {csN, rasN, casN, weN};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Data bus ownership and timing.
  property p_rd_lat;
    pins == PIN_RD && cke && $past(cke) && byteMask == 4'h0 |-> ##2 dqDevOe == 4'hF;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read data missing two cycles after read");
  property p_rd_mask;
    |$past(byteMask, 2) |-> (dqDevOe & $past(byteMask, 2)) == 4'h0;
  endproperty
  a_rd_mask: assert property (p_rd_mask)
    else $error("masked lane driven by device");
  property p_wr_oe;
    pins == PIN_WR |-> dqCtlOe == ~byteMask;
  endproperty
  a_wr_oe: assert property (p_wr_oe)
    else $error("write lanes do not follow mask");
  property p_excl;
    (dqCtlOe & dqDevOe) == 4'h0;
  endproperty
  a_excl: assert property (p_excl)
    else $error("both ends drive one lane");
  property p_ctl_oe;
    $rose(|dqCtlOe) |-> pins == PIN_WR;
  endproperty
  a_ctl_oe: assert property (p_ctl_oe)
    else $error("controller drives data without write");
  property p_dev_rise;
    $rose(|dqDevOe) |-> $past(pins, 2) == PIN_RD;
  endproperty
  a_dev_rise: assert property (p_dev_rise)
    else $error("device drives data without read");
  // ==========================================================================
  // Command pacing and clock gating.
  property p_nop;
    !csN && pins != PIN_NOP |=> pins == PIN_NOP;
  endproperty
  a_nop: assert property (p_nop)
    else $error("no idle pattern after command");
  property p_susp;
    !cke ##1 !cke |=> $stable(dqDevOe);
  endproperty
  a_susp: assert property (p_susp)
    else $error("device output moved while clock gated");
  c_rd: cover property (pins == PIN_RD && byteMask != 4'h0);
  c_wr: cover property (pins == PIN_WR && byteMask != 4'h0);
  c_pd: cover property ($fell(cke));
endmodule : sdc_chk

// [verif/sdc_tb.sv]
// Testbench joining controller and device ends through sdc_if.
// Assumes package, interface and both ends are compiled first.
`timescale 1ns/1ps
module sdc_command_interface_tb;
  import sdc_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic [31:0] r;
  logic [7:0] c0;
  logic [3:0] bankOpen;
  logic powerDown;
  logic selfRefresh;
  int n_fail = 0;
  int n_compared = 0;
  sdc_if sdc_if_i ();
  sdc_ctrl sdc_ctrl_i (.link(sdc_if_i), .clk_sys(clk_sys), .rstn(rstn), .clkEn(1'b1),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata));
  sdc_device sdc_device_i (.link(sdc_if_i), .clk_sys(clk_sys), .rstn(rstn),
    .bankOpen(bankOpen), .powerDown(powerDown), .selfRefresh(selfRefresh));
  sdc_chk sdc_chk_i (.clk_sys(clk_sys), .rstn(rstn), .cke(sdc_if_i.cke),
    .csN(sdc_if_i.csN), .rasN(sdc_if_i.rasN), .casN(sdc_if_i.casN), .weN(sdc_if_i.weN),
    .byteMask(sdc_if_i.byteMask), .dqCtlOe(sdc_if_i.dqCtlOe), .dqDevOe(sdc_if_i.dqDevOe));
  // Free-running 10 MHz system clock.
  always #50 clk_sys = ~clk_sys;
  // ==========================================================================
  // Access tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    #1;
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #10 r = regRdata;
  endtask : rd
  // The wait covers command spacing and an eight-beat burst at latency two.
  task automatic cmd(input sdc_op_t op, input logic [1:0] b, input logic [11:0] a,
                     input logic [3:0] m);
    wr(REG_CMD, {11'h0, m, a, b, op});
    repeat (12) @(posedge clk_sys);
  endtask : cmd
  task automatic burst(input logic [11:0] a, input logic [31:0] w, input logic [7:0] n);
    rd(REG_STATUS);
    c0 = r[15:8];
    cmd(OP_RD, 2'h1, a, 4'h0);
    rd(REG_RDATA);
    chk(r, w);
    rd(REG_STATUS);
    chk({24'h0, r[15:8] - c0}, {24'h0, n});
  endtask : burst
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ==========================================================================
  // Main sequence; memory has no reset, so every word whose data is checked is written first.
  initial begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(REG_CTRL);
    chk(r, 32'h1);
    rd(8'h14);
    chk(r, 32'h0);
    cmd(OP_MRS, 2'h0, 12'h222, 4'h0);
    cmd(OP_ACT, 2'h1, 12'h005, 4'h0);
    chk({28'h0, bankOpen}, 32'h2);
    for (int i = 0; i < 8; i++) begin
      wr(REG_WDATA, 32'hA5000000 | i);
      cmd(OP_WR, 2'h1, 12'h010 + 12'(i), 4'h0);
    end
    wr(REG_WDATA, 32'hFFFFFFFF);
    cmd(OP_WR, 2'h1, 12'h010, 4'h5);
    burst(12'h011, 32'hFF00FF00, 8'h4);
    cmd(OP_PRE, 2'h0, 12'h400, 4'h0);
    chk({28'h0, bankOpen}, 32'h0);
    // Every fixed burst length, starting at the masked word.
    for (int b = 0; b < 4; b++) begin
      cmd(OP_MRS, 2'h0, 12'h220 | 12'(b), 4'h0);
      cmd(OP_ACT, 2'h1, 12'h005, 4'h0);
      burst(12'h010, (b == 0) ? 32'hFF00FF00 : 32'hA5000000 | ((1 << b) - 1), 8'(1 << b));
      cmd(OP_PRE, 2'h1, 12'h000, 4'h0);
      chk({28'h0, bankOpen}, 32'h0);
    end
    cmd(OP_MRS, 2'h0, 12'h22A, 4'h0);
    cmd(OP_ACT, 2'h1, 12'h005, 4'h0);
    cmd(OP_RD, 2'h1, 12'h010, 4'h8);
    burst(12'h411, 32'hA5000002, 8'h4);
    chk({28'h0, bankOpen}, 32'h0);
    cmd(OP_RD, 2'h1, 12'h011, 4'h0);
    rd(REG_STATUS);
    chk({31'h0, r[ST_ERR]}, 32'h1);
    wr(REG_STATUS, 32'h1);
    cmd(OP_MRS, 2'h0, 12'h227, 4'h0);
    cmd(OP_ACT, 2'h0, 12'h005, 4'h0);
    cmd(OP_ACT, 2'h2, 12'h006, 4'h0);
    cmd(OP_PRE, 2'h2, 12'h000, 4'h0);
    chk({28'h0, bankOpen}, 32'h1);
    // A second row on an open bank must be refused and flagged.
    cmd(OP_ACT, 2'h0, 12'h007, 4'h0);
    rd(REG_STATUS);
    chk({31'h0, r[ST_ERR]}, 32'h1);
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS);
    c0 = r[15:8];
    cmd(OP_RD, 2'h0, 12'h000, 4'h0);
    cmd(OP_STOP, 2'h0, 12'h000, 4'h0);
    rd(REG_STATUS);
    chk({31'h0, (r[15:8] - c0) < 8'h14}, 32'h1);
    // Refresh falls due while a row is open and goes out once the bank closes.
    wr(REG_CTRL, 32'h3);
    repeat (REFI_CYC + 40) @(posedge clk_sys);
    rd(REG_STATUS);
    chk({31'h0, r[ST_REFDUE]}, 32'h1);
    cmd(OP_PRE, 2'h0, 12'h400, 4'h0);
    rd(REG_STATUS);
    chk({31'h0, r[ST_REFDUE]}, 32'h0);
    wr(REG_CTRL, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, powerDown}, 32'h1);
    chk({31'h0, selfRefresh}, 32'h0);
    wr(REG_CTRL, 32'h1);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, powerDown}, 32'h0);
    tally_and_finish();
  end
  // Watchdog: the sequence needs about a thousand cycles; this allows four times that.
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule : sdc_command_interface_tb
